// File: trf_pkg.sv
package trf_pkg;

	// ==========================================================
	// Clock and conversion timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned CONV_RATE_HZ = 16;
	localparam int unsigned NS_PER_SECOND = 1000000000;
	localparam int unsigned CONV_PERIOD_NS = NS_PER_SECOND / CONV_RATE_HZ;
	localparam int unsigned CONV_PERIOD_CYCLES = CONV_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned CONV_CNT_W = 23;

	// ==========================================================
	// Measurement and result format
	localparam int unsigned MEAS_W = 16;
	localparam int unsigned FRAC_BITS = 4;
	localparam int unsigned RESULT_BITS = 12;
	localparam int unsigned BYTE_W = 8;
	localparam logic [3:0] LOW_PAD = 4'h0;
	localparam logic [7:0] CODE_MIN = 8'h00;
	localparam logic [7:0] STD_CODE_MAX = 8'h7f;
	localparam logic [7:0] EXT_CODE_MAX = 8'hff;
	localparam logic [3:0] FRAC_ZERO = 4'h0;
	// Limits in sixteenths of a degree
	localparam logic signed [16:0] EXT_OFFSET_Q = 17'sh00400;
	localparam logic signed [16:0] STD_LIMIT_Q = 17'sh00800;
	localparam logic signed [16:0] EXT_LIMIT_Q = 17'sh01000;
	localparam logic signed [16:0] ZERO_Q = 17'sh00000;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RESULT_RESET = 8'h00;
	localparam logic RANGE_RESET = 1'b0;

	typedef enum logic [1:0] {
		TRF_IDLE,
		TRF_WAIT_LOCAL,
		TRF_WAIT_REMOTE
	} trf_state_e;

endpackage : trf_pkg

// File: trf_top.sv
`timescale 1ns/1ps

// What this block does
// - Each local and remote result is a 12-bit code with a step of 0.0625 degrees.
// - In standard range any temperature below zero gives an integer code of 00h.
// - In standard range any temperature above 127 degrees saturates to 7Fh.
// - Range select high chooses the extended range and extended binary format.
// - A range change applies from the next conversion on, never to one under way.
// - Extended range adds 64 (40h) to the standard integer value, giving unsigned codes.
// - Extended range spans -64 degrees (00h) to 191 degrees (FFh), saturating beyond.
// - From reset on, conversions run at 16 per second.
// - Each result is a high byte of whole degrees and a low byte with the fraction in 7:4.
module trf_top
	import trf_pkg::*;
#(
	parameter int unsigned PERIOD_CYCLES = CONV_PERIOD_CYCLES
)
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic rangeSelect,
	input wire logic measValid,
	input wire logic measRemote,
	input wire logic signed [MEAS_W-1:0] measTemp,
	output logic convStart,
	output logic convBusy,
	output logic convRange,
	output logic [BYTE_W-1:0] localHigh,
	output logic [BYTE_W-1:0] localLow,
	output logic [BYTE_W-1:0] remoteHigh,
	output logic [BYTE_W-1:0] remoteLow,
	output logic localUpdated,
	output logic remoteUpdated
);

	// ==========================================================
	// Formatting
	function automatic logic [2*BYTE_W-1:0] fmtResult(
		input logic signed [MEAS_W-1:0] t,
		input logic ext
	);
		logic signed [16:0] v;
		logic [2*BYTE_W-1:0] r;
		// One guard bit so the offset can never wrap the sign
		v = {t[MEAS_W-1], t};
		if (ext)
		begin
			v = v + EXT_OFFSET_Q;
		end
		if (v < ZERO_Q)
		begin
			r = {CODE_MIN, FRAC_ZERO, LOW_PAD};
		end
		else if (!ext && v >= STD_LIMIT_Q)
		begin
			// Saturated codes carry a zero fraction
			r = {STD_CODE_MAX, FRAC_ZERO, LOW_PAD};
		end
		else if (ext && v >= EXT_LIMIT_Q)
		begin
			r = {EXT_CODE_MAX, FRAC_ZERO, LOW_PAD};
		end
		else
		begin
			// Whole degrees high, fraction left-justified low
			r = {v[RESULT_BITS-1:FRAC_BITS], v[FRAC_BITS-1:0], LOW_PAD};
		end
		return r;
	endfunction : fmtResult

	// ==========================================================
	// Conversion timer
	// Reload one short, the start cycle counts too
	localparam logic [CONV_CNT_W-1:0] RELOAD = CONV_CNT_W'(PERIOD_CYCLES - 1);

	logic [CONV_CNT_W-1:0] periodCnt;
	trf_state_e state;
	logic startNow;
	logic acceptLocal;
	logic acceptRemote;
	logic [2*BYTE_W-1:0] formatted;

	// An overrun conversion delays the next start rather than dropping it
	assign startNow = (periodCnt == '0) && (state == TRF_IDLE);
	// A result for the wrong channel, or while idle, is dropped
	assign acceptLocal = measValid && !measRemote && (state == TRF_WAIT_LOCAL);
	assign acceptRemote = measValid && measRemote && (state == TRF_WAIT_REMOTE);
	assign formatted = fmtResult(measTemp, convRange);

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			periodCnt <= '0;
		end
		else if (startNow)
		begin
			periodCnt <= RELOAD;
		end
		else if (periodCnt != '0)
		begin
			periodCnt <= periodCnt - 1'b1;
		end
	end

	// ==========================================================
	// Conversion sequence: local then remote
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state <= TRF_IDLE;
		end
		else
		begin
			// Local always precedes remote within one conversion
			unique case (state)
				TRF_IDLE:
				begin
					if (startNow)
					begin
						state <= TRF_WAIT_LOCAL;
					end
				end
				TRF_WAIT_LOCAL:
				begin
					if (acceptLocal)
					begin
						state <= TRF_WAIT_REMOTE;
					end
				end
				TRF_WAIT_REMOTE:
				begin
					if (acceptRemote)
					begin
						state <= TRF_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Start strobe and busy flag
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			convStart <= 1'b0;
			convBusy <= 1'b0;
		end
		else
		begin
			convStart <= startNow;
			// Busy drops in the same edge that stores the remote result
			convBusy <= startNow || (state != TRF_IDLE && !acceptRemote);
		end
	end

	// ==========================================================
	// Range latch
	// Range is frozen per conversion so both channels share one format
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			convRange <= RANGE_RESET;
		end
		else if (startNow)
		begin
			convRange <= rangeSelect;
		end
	end

	// ==========================================================
	// Result bytes, one set per channel: 0 local, 1 remote
	logic [1:0] chanAccept;
	logic [BYTE_W-1:0] chanHigh [2];
	logic [BYTE_W-1:0] chanLow [2];
	logic chanUpdated [2];

	assign chanAccept = {acceptRemote, acceptLocal};

	for (genvar ch = 0; ch < 2; ch++)
	begin : g_chan
		always_ff @(posedge sys_clk or posedge sys_rst)
		begin
			if (sys_rst)
			begin
				chanHigh[ch] <= RESULT_RESET;
				chanLow[ch] <= RESULT_RESET;
			end
			else if (chanAccept[ch])
			begin
				// Both bytes in one edge so a read never mixes two conversions
				chanHigh[ch] <= formatted[2*BYTE_W-1:BYTE_W];
				chanLow[ch] <= formatted[BYTE_W-1:0];
			end
		end

		always_ff @(posedge sys_clk or posedge sys_rst)
		begin
			if (sys_rst)
			begin
				chanUpdated[ch] <= 1'b0;
			end
			else
			begin
				chanUpdated[ch] <= chanAccept[ch];
			end
		end
	end

	// Outputs are the flops themselves, nothing in between
	assign localHigh = chanHigh[0];
	assign localLow = chanLow[0];
	assign remoteHigh = chanHigh[1];
	assign remoteLow = chanLow[1];
	assign localUpdated = chanUpdated[0];
	assign remoteUpdated = chanUpdated[1];

endmodule : trf_top

// File: trf_monitor.sv
`timescale 1ns/1ps
module trf_monitor (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic rangeSelect,
	input wire logic convStart,
	input wire logic convBusy,
	input wire logic convRange,
	input wire logic [7:0] localHigh,
	input wire logic [7:0] localLow,
	input wire logic [7:0] remoteHigh,
	input wire logic [7:0] remoteLow,
	input wire logic localUpdated,
	input wire logic remoteUpdated
);
	// ==========================================================
	// Result port, range latch and start/busy checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence s_pulse;
		!convStart && convBusy;
	endsequence
	property p_pad;
		localLow[3:0] == 4'h0 && remoteLow[3:0] == 4'h0;
	endproperty
	a_pad: assert property (p_pad) else $error("low nibble set");
	property p_locPair;
		!$stable({localHigh, localLow}) |-> localUpdated;
	endproperty
	a_locPair: assert property (p_locPair) else $error("local split");
	property p_remPair;
		!$stable({remoteHigh, remoteLow}) |-> remoteUpdated;
	endproperty
	a_remPair: assert property (p_remPair) else $error("remote split");
	property p_range;
		convStart |-> convRange == $past(rangeSelect);
	endproperty
	a_range: assert property (p_range) else $error("range not latched");
	property p_hold;
		convBusy && $past(convBusy) |-> $stable(convRange);
	endproperty
	a_hold: assert property (p_hold) else $error("range moved");
	property p_std;
		!convRange && localUpdated |-> localHigh <= 8'h7f;
	endproperty
	a_std: assert property (p_std) else $error("std over 7f");
	property p_pulse;
		convStart |-> convBusy ##1 s_pulse;
	endproperty
	a_pulse: assert property (p_pulse) else $error("start pulse");
	property p_busy;
		(localUpdated |-> convBusy) and (remoteUpdated |-> !convBusy);
	endproperty
	a_busy: assert property (p_busy) else $error("busy order");
endmodule : trf_monitor
bind trf_top trf_monitor trf_monitor_inst (.sys_clk, .sys_rst, .rangeSelect, .convStart,
	.convBusy, .convRange, .localHigh, .localLow, .remoteHigh, .remoteLow, .localUpdated,
	.remoteUpdated);

// File: trf_front_model.sv
`timescale 1ns/1ps
module trf_front_model (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic convStart,
	input wire logic signed [15:0] locT,
	input wire logic signed [15:0] remT,
	output logic measValid,
	output logic measRemote,
	output logic signed [15:0] measTemp
);
	logic [2:0] cnt;
	// Local then remote back to back; data scrambled when idle
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt <= 3'h0;
			measValid <= 1'b0;
			measRemote <= 1'b0;
			measTemp <= 16'sh0000;
		end
		else
		begin
			cnt <= convStart ? 3'h1 : (cnt != 3'h0 && cnt < 3'h3) ? cnt + 3'h1 : 3'h0;
			measValid <= cnt == 3'h1 || cnt == 3'h2;
			measRemote <= cnt == 3'h2;
			measTemp <= cnt == 3'h1 ? locT : cnt == 3'h2 ? remT : ~measTemp;
		end
	end
endmodule : trf_front_model

// File: trf_top_tb_top.sv
`timescale 1ns/1ps
module trf_top_tb_top;
	logic sys_clk = 1'b0;
	logic sys_rst;
	logic rangeSelect = 1'b0;
	logic measValid, measRemote, convStart, convBusy, convRange, localUpdated, remoteUpdated;
	logic signed [15:0] measTemp;
	logic signed [15:0] locT = 16'sh0000;
	logic signed [15:0] remT = 16'sh0000;
	logic [7:0] localHigh, localLow, remoteHigh, remoteLow;
	int errCount = 0;
	int checked = 0;
	int cycles = 0;
	localparam int PERIOD = 20;
	initial
	begin
		forever #5 sys_clk = ~sys_clk;
	end
	trf_top #(.PERIOD_CYCLES(PERIOD)) trf_top_inst (.sys_clk, .sys_rst, .rangeSelect, .measValid,
		.measRemote, .measTemp, .convStart, .convBusy, .convRange, .localHigh, .localLow,
		.remoteHigh, .remoteLow, .localUpdated, .remoteUpdated);
	trf_front_model trf_front_model_inst (.sys_clk, .sys_rst, .convStart, .locT, .remT,
		.measValid, .measRemote, .measTemp);
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e)
		begin
			errCount++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task test_done;
		if (errCount == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	// Range flipped mid-conversion: result must keep the latched format
	task conv(input logic rs, input logic [15:0] lt, input logic [15:0] rt, input logic [31:0] e);
		rangeSelect <= rs;
		locT <= lt;
		remT <= rt;
		@(posedge sys_clk iff convStart);
		rangeSelect <= !rs;
		@(posedge sys_clk iff remoteUpdated);
		chk("localHigh", localHigh, e[31:24]);
		chk("localLow", localLow, e[23:16]);
		chk("remoteHigh", remoteHigh, e[15:8]);
		chk("remoteLow", remoteLow, e[7:0]);
		chk("convRange", {7'h00, convRange}, {7'h00, rs});
	endtask : conv
	task std_range;
		conv(1'b0, 16'h0198, 16'hfff0, 32'h19800000);
		conv(1'b0, 16'h07ff, 16'h0960, 32'h7ff07f00);
	endtask : std_range
	task ext_range;
		conv(1'b1, 16'hfc00, 16'hfbf0, 32'h00000000);
		conv(1'b1, 16'h0bff, 16'h0c00, 32'hfff0ff00);
		conv(1'b1, 16'h0001, 16'hfce0, 32'h40100e00);
	endtask : ext_range
	// Cycles from one start strobe to the next
	task conv_rate;
		int n;
		n = 0;
		@(posedge sys_clk iff convStart);
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (!convStart);
		chk("startGap", n[7:0], 8'(PERIOD));
	endtask : conv_rate
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			errCount++;
			test_done;
		end
	end
	initial
	begin
		sys_rst = 1'b1;
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		std_range;
		ext_range;
		conv_rate;
		test_done;
	end
endmodule : trf_top_tb_top
